// ===== inc/pdr_pkg.sv
package pdr_pkg;

   // ***************************************************************
   // geometry
   // ***************************************************************
   localparam int NUM_GROUPS = 2;
   localparam int PINS_PER_GROUP = 32;
   localparam int ADDR_W = 8;
   localparam int GRP_SEL_BIT = 7;
   localparam int OFS_W = 7;
   localparam int DATA_W = 32;
   localparam int LANE_W = 8;
   localparam int NUM_LANES = 4;

   // ***************************************************************
   // register offsets within one group
   // ***************************************************************
   localparam logic [6:0] OFS_PIN_DIRECTION = 7'h00;
   localparam logic [6:0] OFS_PIN_DIRECTION_CLEAR = 7'h04;
   localparam logic [6:0] OFS_PIN_DIRECTION_SET = 7'h08;
   localparam logic [6:0] OFS_PIN_DIRECTION_TOGGLE = 7'h0C;
   localparam logic [ADDR_W-1:0] GROUP_STRIDE = 8'h80;

   localparam logic [31:0] PIN_DIRECTION_RESET = 32'h00000000;
   localparam logic [31:0] RDATA_IDLE = 32'h00000000;

   // ***************************************************************
   // direction-write operations
   // ***************************************************************
   typedef enum logic [3:0] {
      PDR_OP_WRITE = 4'h1,
      PDR_OP_CLEAR = 4'h2,
      PDR_OP_SET = 4'h4,
      PDR_OP_TOGGLE = 4'h8
   } pdr_op_t;

   typedef struct packed {
      logic valid;
      pdr_op_t op;
      logic [31:0] mask;
      logic [31:0] data;
   } pdr_wr_t;

endpackage

// ===== logic/pdr_group.sv
`timescale 1ns/1ps
module pdr_group (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // write request
   input wire pdr_pkg::pdr_wr_t wr_i,
   // state
   output logic [31:0] dir_o
);
   import pdr_pkg::*;

   logic [31:0] dir_q;
   logic [31:0] dir_d;

   always_comb begin
      dir_d = dir_q;
      if (wr_i.valid) begin
         unique case (wr_i.op)
            PDR_OP_WRITE: dir_d = (dir_q & ~wr_i.mask) | (wr_i.data & wr_i.mask);
            PDR_OP_CLEAR: dir_d = dir_q & ~(wr_i.data & wr_i.mask);
            PDR_OP_SET: dir_d = dir_q | (wr_i.data & wr_i.mask);
            PDR_OP_TOGGLE: dir_d = dir_q ^ (wr_i.data & wr_i.mask);
            default: dir_d = dir_q;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_q <= PIN_DIRECTION_RESET;
      end else begin
         dir_q <= dir_d;
      end
   end

   assign dir_o = dir_q;
endmodule

// ===== logic/pdr_port.sv
`timescale 1ns/1ps
module pdr_port (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pdr_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // protection
   input wire logic write_protect_i,
   // pin direction, 1 = output
   output logic [pdr_pkg::NUM_GROUPS*pdr_pkg::PINS_PER_GROUP-1:0] pin_output_enable_o
);
   import pdr_pkg::*;

   // ***************************************************************
   // decode
   // ***************************************************************
   logic req;
   logic [OFS_W-1:0] ofs;
   logic grp;
   logic hit;
   logic view_dir;
   logic view_clr;
   logic view_set;
   logic view_tgl;
   logic wr_ok;
   pdr_op_t op;
   logic [31:0] mask;
   logic [NUM_LANES-1:0] lane_en;
   logic [31:0] dir [NUM_GROUPS];
   logic [31:0] grp_rd [NUM_GROUPS];
   logic [NUM_GROUPS-1:0] grp_sel;
   logic [31:0] dir_rd;
   logic [31:0] rsel;
   pdr_wr_t wr [NUM_GROUPS];

   // one-hot bus answer states
   typedef enum logic [2:0] {
      PDR_BUS_IDLE = 3'h1,
      PDR_BUS_ACK = 3'h2,
      PDR_BUS_ERR = 3'h4
   } pdr_bus_st_t;

   pdr_bus_st_t state_q;
   pdr_bus_st_t state_d;
   logic [DATA_W-1:0] rdat_q;
   logic [DATA_W-1:0] rdat_d;

   // taken only from idle, so a strobe held over the answer is not served twice
   assign req = wb_cyc_i && wb_stb_i && (state_q == PDR_BUS_IDLE);
   assign ofs = wb_adr_i[OFS_W-1:0];
   assign grp = wb_adr_i[GRP_SEL_BIT];
   // protected writes still get their ack but change nothing
   assign wr_ok = req && hit && wb_we_i && !write_protect_i;

   // one select per view of the direction register
   assign view_dir = (ofs == OFS_PIN_DIRECTION);
   assign view_clr = (ofs == OFS_PIN_DIRECTION_CLEAR);
   assign view_set = (ofs == OFS_PIN_DIRECTION_SET);
   assign view_tgl = (ofs == OFS_PIN_DIRECTION_TOGGLE);
   // anything else in the group window is unmapped and answered with err
   assign hit = view_dir || view_clr || view_set || view_tgl;

   always_comb begin
      op = PDR_OP_WRITE;
      if (view_clr) begin
         op = PDR_OP_CLEAR;
      end else if (view_set) begin
         op = PDR_OP_SET;
      end else if (view_tgl) begin
         op = PDR_OP_TOGGLE;
      end
   end

   // ***************************************************************
   // byte lanes
   // ***************************************************************
   genvar l;
   generate
      for (l = 0; l < NUM_LANES; l++) begin : gen_lane
         assign lane_en[l] = wb_sel_i[l];
         // a write touches only the lanes that are selected
         assign mask[l*LANE_W +: LANE_W] = {LANE_W{lane_en[l]}};
         // unselected lanes read back as zero
         assign rsel[l*LANE_W +: LANE_W] = lane_en[l] ? dir_rd[l*LANE_W +: LANE_W]
            : {LANE_W{1'h0}};
      end
   endgenerate

   // ***************************************************************
   // read path
   // ***************************************************************
   // group selects are one-hot, so an or of the gated copies is the read mux
   always_comb begin
      dir_rd = {PINS_PER_GROUP{1'h0}};
      for (int i = 0; i < NUM_GROUPS; i++) begin
         dir_rd = dir_rd | grp_rd[i];
      end
   end

   // ***************************************************************
   // groups
   // ***************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_GROUPS; g++) begin : gen_grp
         // each group owns a full register copy, chosen by the group bit
         assign grp_sel[g] = (int'(grp) == g);
         always_comb begin
            wr[g].valid = wr_ok && grp_sel[g];
            wr[g].op = op;
            wr[g].mask = mask;
            wr[g].data = wb_dat_i;
         end
         pdr_group u_group (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .wr_i(wr[g]),
            .dir_o(dir[g])
         );
         assign pin_output_enable_o[g*PINS_PER_GROUP +: PINS_PER_GROUP] = dir[g];
         assign grp_rd[g] = grp_sel[g] ? dir[g] : {PINS_PER_GROUP{1'h0}};
      end
   endgenerate

   // ***************************************************************
   // bus answer
   // ***************************************************************
   always_comb begin
      state_d = state_q;
      rdat_d = rdat_q;
      unique case (state_q)
         PDR_BUS_IDLE: begin
            if (req) begin
               state_d = hit ? PDR_BUS_ACK : PDR_BUS_ERR;
               // every view reads the direction state, unmapped reads return zero
               rdat_d = hit ? rsel : RDATA_IDLE;
            end
         end
         PDR_BUS_ACK: begin
            state_d = PDR_BUS_IDLE;
         end
         PDR_BUS_ERR: begin
            state_d = PDR_BUS_IDLE;
         end
         // an upset state code falls back to idle rather than hang the bus
         default: begin
            state_d = PDR_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= PDR_BUS_IDLE;
         rdat_q <= RDATA_IDLE;
      end else begin
         state_q <= state_d;
         rdat_q <= rdat_d;
      end
   end

   // ack and err are one-cycle pulses straight from the state flops
   assign wb_ack_o = (state_q == PDR_BUS_ACK);
   assign wb_err_o = (state_q == PDR_BUS_ERR);
   assign wb_dat_o = rdat_q;
endmodule

// ===== testbench/pdr_port_properties.sv
`timescale 1ns/1ps
module pdr_port_properties (
   input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i, wb_dat_o,
   input wire logic wb_ack_o, wb_err_o, write_protect_i,
   input wire logic [63:0] pin_output_enable_o
);
   wire t = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
   wire w = t & wb_we_i & !write_protect_i & wb_sel_i == 4'hF & !wb_adr_i[7];
   wire [31:0] g = pin_output_enable_o[31:0];
   wire [31:0] m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire wl = t & wb_we_i & !write_protect_i & !wb_adr_i[7];
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack; t |=> wb_ack_o ^ wb_err_o; endproperty
   a_ack: assert property (p_ack) else $error("no answer");
   property p_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_one: assert property (p_one) else $error("long ack");
   property p_wp; t && wb_we_i && write_protect_i |=> $stable(pin_output_enable_o); endproperty
   a_wp: assert property (p_wp) else $error("protect");
   property p_rd; t && !wb_we_i && wb_sel_i == 4'hF && wb_adr_i[6:4] == 3'h0
      && wb_adr_i[1:0] == 2'h0 |=> wb_dat_o ==
      ($past(wb_adr_i[7]) ? pin_output_enable_o[63:32] : g); endproperty
   a_rd: assert property (p_rd) else $error("read");
   property p_dir; w && wb_adr_i[6:0] == 7'h00 |=> g == $past(wb_dat_i); endproperty
   a_dir: assert property (p_dir) else $error("dir");
   property p_clr; w && wb_adr_i[6:0] == 7'h04 |=> g == ($past(g) & ~$past(wb_dat_i)); endproperty
   a_clr: assert property (p_clr) else $error("clr");
   property p_set; w && wb_adr_i[6:0] == 7'h08 |=> g == ($past(g) | $past(wb_dat_i)); endproperty
   a_set: assert property (p_set) else $error("set");
   property p_tgl; w && wb_adr_i[6:0] == 7'h0C |=> g == ($past(g) ^ $past(wb_dat_i)); endproperty
   a_tgl: assert property (p_tgl) else $error("tgl");
   property p_lane; wl && wb_adr_i[6:0] == 7'h00 |=>
      g == (($past(g) & ~$past(m)) | ($past(wb_dat_i) & $past(m))); endproperty
   a_lane: assert property (p_lane) else $error("lane");
   property p_err; t && !(wb_adr_i[6:0] inside {7'h00, 7'h04, 7'h08, 7'h0C}) |=> wb_err_o
      && !wb_ack_o && wb_dat_o == 32'h0 && $stable(pin_output_enable_o); endproperty
   a_err: assert property (p_err) else $error("unmapped");
   property p_iso; t && wb_we_i && wb_adr_i[7] |=> $stable(g); endproperty
   a_iso: assert property (p_iso) else $error("group isolation");
   property p_rst; disable iff (1'h0) rst_i |=> pin_output_enable_o == 64'h0
      && !wb_ack_o && !wb_err_o; endproperty
   a_rst: assert property (p_rst) else $error("reset");
endmodule

// ===== testbench/pdr_port_tb.sv
`timescale 1ns/1ps
module pdr_port_tb;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, write_protect_i = 0;
   logic [7:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
   logic wb_ack_o, wb_err_o, er;
   logic [63:0] pin_output_enable_o;
   int failures = 0, n_tests = 0, cyc_n = 0;
   pdr_port dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .wb_err_o(wb_err_o),
      .write_protect_i(write_protect_i),
      .pin_output_enable_o(pin_output_enable_o)
   );
   always #4 clk_i = ~clk_i;
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
         input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, s, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      rd = wb_dat_o;
      er = wb_err_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      n_tests++;
      if (x !== y) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, x, y);
      end
   endtask
   task automatic t_reset;
      chk("pins", 32'h0, pin_output_enable_o[31:0] | pin_output_enable_o[63:32]);
      bus(1'b0, 8'h80, 4'hF, 32'h0);
      chk("grp1", 32'h0, rd);
      bus(1'b0, 8'h10, 4'hF, 32'h0);
      chk("err", 32'h1, {31'h0, er});
   endtask
   task automatic t_ops;
      bus(1'b1, 8'h00, 4'hF, 32'hA5A5F00F);
      bus(1'b1, 8'h08, 4'hF, 32'h000000F0);
      chk("set", 32'hA5A5F0FF, pin_output_enable_o[31:0]);
      bus(1'b1, 8'h04, 4'hF, 32'h0000000F);
      chk("clr", 32'hA5A5F0F0, pin_output_enable_o[31:0]);
      bus(1'b1, 8'h0C, 4'hF, 32'hFFFF0000);
      for (int i = 0; i < 16; i += 4) begin
         bus(1'b0, 8'(i), 4'hF, 32'h0);
         chk("view", 32'h5A5AF0F0, rd);
      end
   endtask
   task automatic t_lane;
      bus(1'b1, 8'h00, 4'h2, 32'h12345678);
      chk("byte", 32'h5A5A56F0, pin_output_enable_o[31:0]);
      bus(1'b1, 8'h00, 4'hC, 32'h87650000);
      chk("half", 32'h876556F0, pin_output_enable_o[31:0]);
      bus(1'b0, 8'h00, 4'h1, 32'h0);
      chk("rdb", 32'h000000F0, rd);
   endtask
   task automatic t_grp;
      bus(1'b1, 8'h80, 4'hF, 32'h0F0F0001);
      chk("hi", 32'h0F0F0001, pin_output_enable_o[63:32]);
      write_protect_i <= 1'b1;
      bus(1'b1, 8'h08, 4'hF, 32'hFFFFFFFF);
      chk("lo", 32'h876556F0, pin_output_enable_o[31:0]);
      chk("wp ack", 32'h0, {31'h0, er});
      write_protect_i <= 1'b0;
      bus(1'b1, 8'h88, 4'h1, 32'hFFFFFFF0);
      bus(1'b1, 8'h84, 4'h8, 32'hFF000000);
      bus(1'b1, 8'h8C, 4'h3, 32'hFFFFFFFF);
      chk("hi ops", 32'h000FFF0E, pin_output_enable_o[63:32]);
      bus(1'b1, 8'h20, 4'hF, 32'hFFFFFFFF);
      chk("err wr", 32'h1, {31'h0, er});
      chk("lo kept", 32'h876556F0, pin_output_enable_o[31:0]);
   endtask
   task automatic t_rst;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("rst", 32'h0, pin_output_enable_o[31:0] | pin_output_enable_o[63:32]);
      rst_i <= 1'b0;
      bus(1'b0, 8'h8C, 4'hF, 32'h0);
      chk("rst rd", 32'h0, rd);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n > 2000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_ops();
      t_lane();
      t_grp();
      t_rst();
      tally_and_finish();
   end
endmodule
bind pdr_port pdr_port_properties u_chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o),
   .write_protect_i(write_protect_i),
   .pin_output_enable_o(pin_output_enable_o)
);
